// File: rtl/lcs_pkg.sv
package lcs_pkg;

  // ----------------------------------------------------------------
  // Phases of the charge sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LCS_OFF, LCS_PREQUAL, LCS_CC, LCS_CV, LCS_MAINT, LCS_FAULT
  } lcs_phase_t;

  // ----------------------------------------------------------------
  // Current codes: setpoint = 100 mA + code * 50 mA, code 0..13
  // ----------------------------------------------------------------
  localparam logic [3:0] LCS_CODE_100MA = 4'h0;
  localparam logic [3:0] LCS_CODE_500MA = 4'h8;
  localparam logic [3:0] LCS_CODE_750MA = 4'hD;
  localparam int LCS_STEP_MA = 50;
  localparam int LCS_BASE_MA = 100;

  // End-of-charge threshold selection
  localparam logic [1:0] LCS_EOC_0P10C = 2'h0;
  localparam logic [1:0] LCS_EOC_0P15C = 2'h1;
  localparam logic [1:0] LCS_EOC_0P20C = 2'h2;

  // ----------------------------------------------------------------
  // Safety timer: 5.6 hr at 125 MHz through a prescaler
  // ----------------------------------------------------------------
  localparam int LCS_CLK_MHZ = 125;
  localparam int LCS_TIMER_HR_X10 = 56;
  localparam int LCS_PRESCALE = 125000000;
  localparam int LCS_PRE_PER_S = LCS_CLK_MHZ * 1000000 / LCS_PRESCALE;
  localparam int LCS_TIMER_TICKS = LCS_TIMER_HR_X10 * 360 / LCS_PRE_PER_S;

  // Settings from the serial host
  typedef struct packed {
    logic       valid;
    logic [3:0] cc_code;
    logic       v42;
    logic [1:0] eoc_sel;
  } lcs_cfg_t;

  // Synchronised comparator outputs
  typedef struct packed {
    logic src_ok;
    logic batt_above_qual;
    logic batt_at_reg;
    logic batt_below_rst;
    logic i_below_eoc;
    logic temp_ok;
  } lcs_cmp_t;

endpackage : lcs_pkg

// File: rtl/lcs_sequencer.sv
`timescale 1ns/10ps
module lcs_sequencer
  import lcs_pkg::*;
#(
  parameter int PRESCALE = LCS_PRESCALE,
  parameter int TIMER_TICKS = LCS_TIMER_TICKS,
  parameter bit FACTORY_V42 = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic charger_enable,
  input wire logic adaptor_mode,
  input wire logic usb_current_select,
  input wire logic src_ok_raw,
  input wire logic batt_above_qual_raw,
  input wire logic batt_at_reg_raw,
  input wire logic batt_below_rst_raw,
  input wire logic i_below_eoc_raw,
  input wire logic temp_ok_raw,
  input wire lcs_cfg_t host_cfg,
  output logic charge_on,
  output logic precharge_limit,
  output logic cv_regulate,
  output logic [3:0] charge_current,
  output logic reg_level_v42,
  output logic [1:0] eoc_threshold,
  output logic charging_indicator,
  output logic eoc_indicator,
  output logic timer_fault
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  lcs_cmp_t cmp;
  logic en_s;
  logic mode_s;
  logic usb_current_select_s;

  assign raw_in = {charger_enable, adaptor_mode, usb_current_select,
                   src_ok_raw, batt_above_qual_raw, batt_at_reg_raw,
                   batt_below_rst_raw, i_below_eoc_raw, temp_ok_raw};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end

  assign {en_s, mode_s, usb_current_select_s} = s2_reg[8:6];
  assign cmp = lcs_cmp_t'(s2_reg[5:0]);

  // ----------------------------------------------------------------
  // Settings selection
  // ----------------------------------------------------------------
  logic [3:0] prog_code;
  logic [3:0] cur_next;
  logic v42_next;
  logic [1:0] eoc_next;

  always_comb begin
    // Out-of-range host codes clamp to 750 mA
    prog_code = (host_cfg.cc_code > LCS_CODE_750MA) ? LCS_CODE_750MA
                : host_cfg.cc_code;
    if (!mode_s && usb_current_select_s) begin
      cur_next = LCS_CODE_100MA;
    end else if (host_cfg.valid) begin
      cur_next = prog_code;
    end else begin
      cur_next = LCS_CODE_500MA;
    end
    v42_next = host_cfg.valid ? host_cfg.v42 : FACTORY_V42;
    eoc_next = (host_cfg.valid && host_cfg.eoc_sel <= LCS_EOC_0P20C)
               ? host_cfg.eoc_sel : LCS_EOC_0P10C;
  end

  // ----------------------------------------------------------------
  // Safety timer
  // ----------------------------------------------------------------
  lcs_phase_t phase_reg, phase_next;
  logic [$clog2(PRESCALE+1)-1:0] pre_reg, pre_next;
  logic [$clog2(TIMER_TICKS+1)-1:0] tmr_reg, tmr_next;
  logic expired_reg, expired_next;
  logic temp_bad_reg, temp_bad_next;
  logic src_ok_d_reg;
  logic tick;
  logic timing;
  logic timer_done;

  // Counts only while the phase holds in constant current, so any
  // suspension or restart begins the full span again
  assign timing = en_s && cmp.src_ok && cmp.temp_ok
                  && (phase_reg == LCS_CC);
  assign tick = (pre_reg == $bits(pre_reg)'(PRESCALE - 1));
  assign timer_done = (tmr_reg >= $bits(tmr_reg)'(TIMER_TICKS));

  always_comb begin
    pre_next = '0;
    tmr_next = '0;
    if (timing) begin
      pre_next = tick ? '0 : pre_reg + 1'b1;
      tmr_next = tmr_reg + (tick ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
      tmr_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      tmr_reg <= tmr_next;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    phase_next = phase_reg;
    temp_bad_next = temp_bad_reg;
    expired_next = expired_reg;
    if (!en_s || !cmp.src_ok) begin
      phase_next = LCS_OFF;
      expired_next = 1'b0;
      temp_bad_next = 1'b0;
    end else if (!cmp.temp_ok) begin
      // Suspend; timer is cleared so recovery starts fresh
      phase_next = LCS_OFF;
      temp_bad_next = 1'b1;
    end else begin
      temp_bad_next = 1'b0;
      unique case (phase_reg)
        LCS_OFF: begin
          // New source, or temperature recovery with no latched expiry, starts over
          if (!expired_reg) phase_next = LCS_PREQUAL;
        end
        LCS_PREQUAL: begin
          if (cmp.batt_above_qual) phase_next = LCS_CC;
        end
        LCS_CC: begin
          if (timer_done) begin
            expired_next = 1'b1;
            phase_next = LCS_FAULT;
          end else if (cmp.batt_at_reg) begin
            phase_next = LCS_CV;
          end
        end
        LCS_CV: begin
          if (cmp.i_below_eoc) phase_next = LCS_MAINT;
        end
        LCS_MAINT: begin
          if (cmp.batt_below_rst) phase_next = LCS_PREQUAL;
        end
        LCS_FAULT: phase_next = LCS_FAULT;
      endcase
    end
    // Re-insertion of the source clears a latched expiry
    if (cmp.src_ok && !src_ok_d_reg) expired_next = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= LCS_OFF;
      expired_reg <= 1'b0;
      temp_bad_reg <= 1'b0;
      src_ok_d_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      expired_reg <= expired_next;
      temp_bad_reg <= temp_bad_next;
      src_ok_d_reg <= cmp.src_ok;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic charge_on_next;
  logic chg_ind_next;
  logic eoc_ind_next;
  logic precharge_next;
  logic cv_next;

  // Decoded from the next phase so outputs stay one flop from state
  always_comb begin
    precharge_next = (phase_next == LCS_PREQUAL);
    cv_next = (phase_next == LCS_CV);
    charge_on_next = (phase_next == LCS_PREQUAL) || (phase_next == LCS_CC)
                     || (phase_next == LCS_CV);
    chg_ind_next = charge_on_next || expired_next || temp_bad_next;
    eoc_ind_next = (phase_next == LCS_MAINT) || expired_next
                   || temp_bad_next || (en_s == 1'b0 && cmp.src_ok);
    if (phase_next == LCS_MAINT) chg_ind_next = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_on <= 1'b0;
      precharge_limit <= 1'b0;
      cv_regulate <= 1'b0;
      charge_current <= LCS_CODE_500MA;
      reg_level_v42 <= 1'b0;
      eoc_threshold <= LCS_EOC_0P10C;
      charging_indicator <= 1'b0;
      eoc_indicator <= 1'b0;
      timer_fault <= 1'b0;
    end else begin
      charge_on <= charge_on_next;
      precharge_limit <= precharge_next;
      cv_regulate <= cv_next;
      charge_current <= cur_next;
      reg_level_v42 <= v42_next;
      eoc_threshold <= eoc_next;
      charging_indicator <= chg_ind_next;
      eoc_indicator <= eoc_ind_next;
      timer_fault <= expired_next;
    end
  end

endmodule : lcs_sequencer

// File: verif/lcs_far_side.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Source and cell seen through comparators
// ------------------------------------------------------------
module lcs_far_side (
  input wire logic clk,
  input wire logic plug,
  input wire logic adaptor,
  input wire logic stall,
  input wire logic drain,
  input wire logic charge_on,
  input wire logic cv_regulate,
  output logic src_ok_raw,
  output logic adaptor_mode,
  output logic batt_above_qual_raw,
  output logic batt_at_reg_raw,
  output logic batt_below_rst_raw,
  output logic i_below_eoc_raw
);
  int v = 0;
  int t = 0;
  assign src_ok_raw = plug;
  assign adaptor_mode = adaptor;
  assign batt_above_qual_raw = v > 30;
  assign batt_at_reg_raw = v >= 42;
  assign batt_below_rst_raw = v < 40;
  // Taper current only while voltage is held
  assign i_below_eoc_raw = t > 6;
  always @(posedge clk) begin
    if (drain) v <= 35;
    else if (charge_on && !cv_regulate && !stall && v < 42) v <= v + 1;
    t <= cv_regulate ? t + 1 : 0;
  end
endmodule : lcs_far_side

// File: verif/lcs_seq_props.sv
`timescale 1ns/10ps
module lcs_seq_props
  import lcs_pkg::*;
#(
  parameter int PRESCALE = 4,
  parameter int TIMER_TICKS = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic charger_enable,
  input wire logic adaptor_mode,
  input wire logic usb_current_select,
  input wire logic temp_ok_raw,
  input wire lcs_cfg_t host_cfg,
  input wire logic charge_on,
  input wire logic precharge_limit,
  input wire logic cv_regulate,
  input wire logic [3:0] charge_current,
  input wire logic charging_indicator,
  input wire logic eoc_indicator,
  input wire logic timer_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  pre_limit_a: assert property (precharge_limit |-> charge_on && !cv_regulate)
    else $error("precharge limit outside prequal");
  cv_phase_a: assert property (cv_regulate |-> charge_on && !precharge_limit)
    else $error("cv regulate without charge");
  one_step_a: assert property ($rose(cv_regulate) |->
    $past(charge_on && !precharge_limit && !cv_regulate))
    else $error("cv entered not from cc");
  timer_cc_a: assert property ($rose(timer_fault) |->
    $past(charge_on && !precharge_limit && !cv_regulate))
    else $error("timer expiry outside cc");
  fault_leds_a: assert property (timer_fault |->
    charging_indicator && eoc_indicator && !charge_on)
    else $error("timer fault indication wrong");
  enable_off_a: assert property (!charger_enable [*4] |-> !charge_on)
    else $error("charging while disabled");
  temp_off_a: assert property (!temp_ok_raw [*4] |-> !charge_on)
    else $error("charging out of temperature");
  usb_low_a: assert property ((!adaptor_mode && usb_current_select) [*4] |->
    charge_current == LCS_CODE_100MA)
    else $error("usb select high not 100 mA");
  adapt_def_a: assert property ((adaptor_mode && !host_cfg.valid) [*4] |->
    charge_current == LCS_CODE_500MA)
    else $error("adaptor default not 500 mA");
  eoc_cause_a: assert property ($rose(eoc_indicator) && charger_enable &&
    !charging_indicator |-> $past(cv_regulate))
    else $error("end of charge not from cv");
endmodule : lcs_seq_props

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import lcs_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic charger_enable = 1'b0;
  logic usb_current_select = 1'b0;
  logic temp_ok_raw = 1'b1;
  logic plug = 1'b0;
  logic adaptor = 1'b1;
  logic stall = 1'b0;
  logic drain = 1'b0;
  lcs_cfg_t host_cfg = '0;
  logic adaptor_mode, src_ok_raw, batt_above_qual_raw, batt_at_reg_raw;
  logic batt_below_rst_raw, i_below_eoc_raw, charge_on, precharge_limit;
  logic cv_regulate, reg_level_v42, charging_indicator, eoc_indicator;
  logic timer_fault;
  logic [3:0] charge_current;
  logic [1:0] eoc_threshold;
  wire [7:0] st = {2'h0, charge_on, precharge_limit, cv_regulate,
    charging_indicator, eoc_indicator, timer_fault};
  int failures = 0;
  int samples_checked = 0;
  int n;
  always #4 clk = ~clk;
  lcs_sequencer #(.PRESCALE(4), .TIMER_TICKS(5)) i_lcs_sequencer (.*);
  lcs_far_side i_lcs_far_side (.*);
  // ------------------------------------------------------------
  // Compare and wait helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded so a stuck phase shows as a mismatch, not a hang
  task automatic wait_st(input logic [7:0] m, input logic [7:0] e);
    n = 0;
    while ((st & m) !== e && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(st & m, e);
  endtask : wait_st
  task automatic close_out;
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    chk(charge_current, 8'h08);
    plug = 1'b1;
    charger_enable = 1'b1;
    wait_st(8'hFF, 8'h34);
    usb_current_select = 1'b1;
    repeat (4) @(negedge clk);
    chk(charge_current, 8'h08);
    wait_st(8'hFF, 8'h24);
    wait_st(8'hFF, 8'h2C);
    chk(reg_level_v42, 8'h01);
    wait_st(8'hFF, 8'h02);
    chk(eoc_threshold, 8'h00);
    drain = 1'b1;
    @(negedge clk);
    drain = 1'b0;
    wait_st(8'h30, 8'h30);
    wait_st(8'hFF, 8'h02);
    for (int k = 0; k < 4; k++) begin
      host_cfg = '{1'b1, 4'(k * 5), 1'b0, 2'(k)};
      repeat (2) @(negedge clk);
      chk(charge_current, (k == 3) ? 8'h0D : 8'(k * 5));
      chk(eoc_threshold, (k == 3) ? 8'h00 : 8'(k));
      chk(reg_level_v42, 8'h00);
    end
    adaptor = 1'b0;
    repeat (4) @(negedge clk);
    chk(charge_current, 8'h00);
    usb_current_select = 1'b0;
    repeat (4) @(negedge clk);
    chk(charge_current, 8'h0D);
    host_cfg.valid = 1'b0;
    repeat (2) @(negedge clk);
    chk(charge_current, 8'h08);
    chk(reg_level_v42, 8'h01);
    adaptor = 1'b1;
    drain = 1'b1;
    stall = 1'b1;
    @(negedge clk);
    drain = 1'b0;
    wait_st(8'h38, 8'h20);
    repeat (10) @(negedge clk);
    temp_ok_raw = 1'b0;
    wait_st(8'hFF, 8'h06);
    temp_ok_raw = 1'b1;
    wait_st(8'h30, 8'h30);
    wait_st(8'hFF, 8'h07);
    chk(8'(n >= 20 && n < 40), 8'h01);
    charger_enable = 1'b0;
    wait_st(8'hFF, 8'h02);
    close_out();
  end
endmodule : testbench
bind lcs_sequencer lcs_seq_props #(.PRESCALE(PRESCALE),
  .TIMER_TICKS(TIMER_TICKS)) i_lcs_seq_props (.clk, .arst_n,
  .charger_enable, .adaptor_mode, .usb_current_select, .temp_ok_raw,
  .host_cfg, .charge_on, .precharge_limit, .cv_regulate, .charge_current,
  .charging_indicator, .eoc_indicator, .timer_fault);
